// ==== inc/pmbus_cfg_pkg.sv ====
// Shared constants and carrier types for the PMBus configuration command block.
`default_nettype none

package pmbus_cfg_pkg;

    // Command codes of the three commands held here.
    localparam logic [7:0] CODE_INPUT_TURNOFF_THRESHOLD = 8'h36;
    localparam logic [7:0] CODE_CURRENT_OFFSET_TRIM = 8'h39;
    localparam logic [7:0] CODE_OVERVOLTAGE_REACTION = 8'h41;

    // Turn-off threshold: fixed exponent, fixed upper mantissa, range in 0.25 V steps.
    localparam logic [4:0] TURNOFF_EXPONENT = 5'h1E;
    localparam logic [3:0] TURNOFF_FIXED_UPPER = 4'h0;
    localparam int TURNOFF_LOW_WIDTH = 7;
    localparam logic [6:0] TURNOFF_RESET = 7'h10;
    localparam int TURNOFF_MIN = 16;
    localparam int TURNOFF_MAX = 30;
    localparam int TURNOFF_EXP_VALUE = -2;

    // Current offset: fixed exponent, sign at mantissa bit 10, four sign copies, six low bits.
    localparam logic [4:0] OFFSET_EXPONENT = 5'h1C;
    localparam int OFFSET_SIGN_BIT = 10;
    localparam int OFFSET_LOW_WIDTH = 6;
    localparam logic [5:0] OFFSET_LOW_RESET = 6'h00;
    localparam logic OFFSET_SIGN_RESET = 1'b0;

    // Overvoltage reaction byte layout.
    localparam int REACT_SELECT_BIT = 7;
    localparam int REACT_POLICY_MSB = 5;
    localparam int REACT_POLICY_LSB = 3;
    localparam logic REACT_SELECT_RESET = 1'b1;
    localparam logic REACT_POLICY_RESET = 1'b1;
    localparam logic [2:0] POLICY_STAY_OFF = 3'h0;
    localparam logic [2:0] POLICY_RESTART = 3'h7;
    localparam int RETRY_RISE_TIMES = 7;

    // Status bit positions.
    localparam int BYTE_OV_BIT = 5;
    localparam int BYTE_CML_BIT = 1;
    localparam int WORD_VOUT_BIT = 15;
    localparam int CML_BAD_COMMAND_BIT = 7;
    localparam int CML_INVALID_DATA_BIT = 6;
    localparam int VOUT_OV_BIT = 7;

    // Nonvolatile image slots.
    localparam logic [1:0] SLOT_TURNOFF = 2'h0;
    localparam logic [1:0] SLOT_OFFSET = 2'h1;
    localparam logic [1:0] SLOT_REACTION = 2'h2;
    localparam logic [1:0] SLOT_IDLE = 2'h3;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } resp_t;

    typedef struct packed {
        logic [7:0] status_byte;
        logic [15:0] status_word;
        logic [7:0] status_cml;
        logic [7:0] status_vout;
    } status_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_LATCHED_OFF = 2'b01,
        ST_RETRY_WAIT = 2'b10
    } power_state_t;

endpackage

`default_nettype wire

// ==== core/nv_image_store.sv ====
// Small nonvolatile image store with a registered read port.
`default_nettype none

module nv_image_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 3,
    parameter int ADDR_W = 2
) (
    // Clock.
    input wire logic clock,
    // Write port.
    input wire logic write_en,
    input wire logic [ADDR_W-1:0] write_addr,
    input wire logic [WIDTH-1:0] write_data,
    // Read port.
    input wire logic [ADDR_W-1:0] read_addr,
    output logic [WIDTH-1:0] read_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (write_en && (int'(write_addr) < DEPTH)) begin
            mem[write_addr] <= write_data;
        end
        if (int'(read_addr) < DEPTH) begin
            read_data <= mem[read_addr];
        end else begin
            read_data <= '0;
        end
    end

endmodule

`default_nettype wire

// ==== core/pmbus_input_turnoff_threshold_iout_ov_cfg.sv ====
// Input turn-off threshold, current offset and overvoltage reaction commands with status and alert.
// Summary of operation
// RULE_01: In-range threshold writes are rounded to the nearest 0.25 V step and stored.
// RULE_02: Threshold accepts mantissa 16 to 30; resets to 16, meaning 4 V.
// RULE_03: Out-of-range threshold write sets communication and invalid-data bits and raises alert.
// RULE_04: Out-of-range threshold write leaves the stored threshold unchanged.
// RULE_05: Threshold not below turn-on level is rejected, flagged and alerted, value kept.
// RULE_06: Threshold word has fixed read-only exponent minus two and 11-bit mantissa.
// RULE_07: Upper four threshold mantissa bits are fixed; only low bits are writable.
// RULE_08: Store-all request copies all three commands into nonvolatile storage.
// RULE_09: Current offset corrects reported current and overcurrent fault and warning thresholds.
// RULE_10: Offset has 62.5 mA steps, spans -4 A to 3.9375 A, resets zero.
// RULE_11: Offset exponent fixed minus four; out-of-range writes wrap via fixed bits.
// RULE_12: Offset mantissa top bit is writable sign, next four copy it, six low writable.
// RULE_13: Overvoltage fault sets byte, word and vout status bits and raises alert.
// RULE_14: Loop slave NACKs any reaction access, ignores writes, flags bad command, alerts.
// RULE_15: Reaction resets to shutdown, restart, seven rise delay; fixed bit layout.
// RULE_16: Select bit zero keeps regulating through overvoltage, still flags and alerts unmasked.
// RULE_17: Select bit one shuts down on overvoltage and follows the retry policy.
// RULE_18: Retry policy accepts only 000 or 111; others rejected, flagged, alerted.
// RULE_19: Retry delay is read-only mirror of policy bit 5; 111 waits seven rise times.
// RULE_20: Fixed bits ignore writes and always read back their hardwired values.
`default_nettype none

module pmbus_input_turnoff_threshold_iout_ov_cfg #(
    parameter int RISE_CYCLES = 1000,
    parameter int WAIT_W = 24
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Decoded PMBus command and its answer.
    input wire pmbus_cfg_pkg::cmd_t cmd,
    output pmbus_cfg_pkg::resp_t resp,
    input wire logic store_all,
    input wire logic clear_faults,
    // Device conditions.
    input wire logic loop_slave_strap,
    input wire logic [4:0] turnon_mantissa,
    input wire logic overvoltage_fault,
    input wire logic overvoltage_alert_mask,
    // Current measurement and limits in 62.5 mA units.
    input wire logic signed [15:0] current_raw,
    input wire logic signed [15:0] oc_fault_limit,
    input wire logic signed [15:0] oc_warn_limit,
    output logic signed [15:0] current_reported,
    output logic signed [15:0] oc_fault_threshold,
    output logic signed [15:0] oc_warn_threshold,
    // Status, alert and power control.
    output pmbus_cfg_pkg::status_t status,
    output logic smbalert_n,
    output logic regulate,
    output logic soft_start,
    output logic store_busy,
    output logic [15:0] nv_read_data
);

    logic [6:0] turnoff_low, next_turnoff_low;
    logic offset_sign, next_offset_sign;
    logic [5:0] offset_low, next_offset_low;
    logic react_select, next_react_select;
    logic react_policy, next_react_policy;
    logic loop_slave, next_loop_slave;
    logic strap_taken, next_strap_taken;
    pmbus_cfg_pkg::resp_t next_resp;
    pmbus_cfg_pkg::status_t next_status;
    logic next_smbalert_n;
    logic invalid_data_evt, bad_command_evt;
    pmbus_cfg_pkg::power_state_t state, next_state;
    logic [WAIT_W-1:0] wait_count, next_wait_count;
    logic next_regulate, next_soft_start;
    logic signed [15:0] next_current_reported, next_oc_fault_threshold, next_oc_warn_threshold;
    logic [1:0] store_slot, next_store_slot;
    logic next_store_busy;
    logic nv_write_en;
    logic [15:0] nv_write_data;

    localparam logic [WAIT_W-1:0] RETRY_WAIT_CYCLES = WAIT_W'(pmbus_cfg_pkg::RETRY_RISE_TIMES * RISE_CYCLES);

    function automatic logic [15:0] turnoff_word(input logic [6:0] low);
        return {pmbus_cfg_pkg::TURNOFF_EXPONENT, pmbus_cfg_pkg::TURNOFF_FIXED_UPPER, low}; // RULE_06 RULE_07 RULE_20
    endfunction

    function automatic logic [15:0] offset_word(input logic sign, input logic [5:0] low);
        return {pmbus_cfg_pkg::OFFSET_EXPONENT, sign, {4{sign}}, low}; // RULE_11 RULE_12 RULE_20
    endfunction

    function automatic logic [15:0] reaction_word(input logic select, input logic policy);
        return {8'h00, select, 1'b0, {3{policy}}, {3{policy}}}; // RULE_15 RULE_19 RULE_20
    endfunction

    // Converts any linear-format word to a count of 0.25 V steps, rounding to nearest.
    function automatic logic signed [31:0] to_quarter_steps(input logic [15:0] w);
        logic signed [31:0] mant;
        int shift;
        mant = {{21{w[10]}}, w[10:0]};
        shift = int'($signed(w[15:11])) - pmbus_cfg_pkg::TURNOFF_EXP_VALUE;
        if (shift >= 0) begin
            return mant <<< shift;
        end
        return (mant + (32'sd1 <<< (-shift - 1))) >>> (-shift); // RULE_01
    endfunction

    // Configuration registers, command answers and status flags.
    always_comb begin
        logic signed [31:0] q;
        logic [2:0] policy_field;
        q = to_quarter_steps(cmd.data);
        policy_field = cmd.data[pmbus_cfg_pkg::REACT_POLICY_MSB:pmbus_cfg_pkg::REACT_POLICY_LSB];
        next_turnoff_low = turnoff_low;
        next_offset_sign = offset_sign;
        next_offset_low = offset_low;
        next_react_select = react_select;
        next_react_policy = react_policy;
        next_strap_taken = 1'b1;
        next_loop_slave = strap_taken ? loop_slave : loop_slave_strap;
        next_resp = '0;
        invalid_data_evt = 1'b0;
        bad_command_evt = 1'b0;
        if (cmd.valid) begin
            next_resp.valid = 1'b1;
            unique case (cmd.code)
                pmbus_cfg_pkg::CODE_INPUT_TURNOFF_THRESHOLD: begin
                    next_resp.data = turnoff_word(turnoff_low);
                    if (cmd.write) begin
                        if (q < pmbus_cfg_pkg::TURNOFF_MIN || q > pmbus_cfg_pkg::TURNOFF_MAX) begin
                            invalid_data_evt = 1'b1; // RULE_02 RULE_03 RULE_04
                        end else if (q >= $signed({27'h0, turnon_mantissa})) begin
                            invalid_data_evt = 1'b1; // RULE_05
                        end else begin
                            next_turnoff_low = q[6:0]; // RULE_01 RULE_07
                        end
                    end
                end
                pmbus_cfg_pkg::CODE_CURRENT_OFFSET_TRIM: begin
                    next_resp.data = offset_word(offset_sign, offset_low);
                    if (cmd.write) begin
                        next_offset_sign = cmd.data[pmbus_cfg_pkg::OFFSET_SIGN_BIT]; // RULE_11 RULE_12
                        next_offset_low = cmd.data[pmbus_cfg_pkg::OFFSET_LOW_WIDTH-1:0]; // RULE_12
                    end
                end
                pmbus_cfg_pkg::CODE_OVERVOLTAGE_REACTION: begin
                    if (loop_slave) begin
                        next_resp.nack = 1'b1; // RULE_14
                        bad_command_evt = 1'b1; // RULE_14
                    end else begin
                        next_resp.data = reaction_word(react_select, react_policy);
                        if (cmd.write) begin
                            if (policy_field == pmbus_cfg_pkg::POLICY_STAY_OFF ||
                                policy_field == pmbus_cfg_pkg::POLICY_RESTART) begin
                                next_react_select = cmd.data[pmbus_cfg_pkg::REACT_SELECT_BIT];
                                next_react_policy = policy_field[2]; // RULE_18 RULE_19
                            end else begin
                                invalid_data_evt = 1'b1; // RULE_18
                            end
                        end
                    end
                end
                default: begin
                    next_resp.nack = 1'b1;
                    bad_command_evt = 1'b1;
                end
            endcase
        end
        // Clearing first, then events, so a new event in the clearing cycle survives.
        next_status = clear_faults ? '0 : status;
        if (invalid_data_evt) begin
            next_status.status_byte[pmbus_cfg_pkg::BYTE_CML_BIT] = 1'b1; // RULE_03 RULE_05 RULE_18
            next_status.status_cml[pmbus_cfg_pkg::CML_INVALID_DATA_BIT] = 1'b1; // RULE_03 RULE_05 RULE_18
        end
        if (bad_command_evt) begin
            next_status.status_byte[pmbus_cfg_pkg::BYTE_CML_BIT] = 1'b1; // RULE_14
            next_status.status_cml[pmbus_cfg_pkg::CML_BAD_COMMAND_BIT] = 1'b1; // RULE_14
        end
        if (overvoltage_fault) begin
            next_status.status_byte[pmbus_cfg_pkg::BYTE_OV_BIT] = 1'b1; // RULE_13 RULE_16
            next_status.status_word[pmbus_cfg_pkg::WORD_VOUT_BIT] = 1'b1; // RULE_13
            next_status.status_vout[pmbus_cfg_pkg::VOUT_OV_BIT] = 1'b1; // RULE_13
        end
        next_status.status_word[7:0] = next_status.status_byte;
        next_smbalert_n = ~((|next_status.status_cml) |
                            (next_status.status_vout[pmbus_cfg_pkg::VOUT_OV_BIT] & ~overvoltage_alert_mask)); // RULE_03 RULE_13 RULE_16
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            turnoff_low <= pmbus_cfg_pkg::TURNOFF_RESET; // RULE_02
            offset_sign <= pmbus_cfg_pkg::OFFSET_SIGN_RESET; // RULE_10
            offset_low <= pmbus_cfg_pkg::OFFSET_LOW_RESET; // RULE_10
            react_select <= pmbus_cfg_pkg::REACT_SELECT_RESET; // RULE_15
            react_policy <= pmbus_cfg_pkg::REACT_POLICY_RESET; // RULE_15
            loop_slave <= 1'b0;
            strap_taken <= 1'b0;
            resp <= '0;
            status <= '0;
            smbalert_n <= 1'b1;
        end else begin
            turnoff_low <= next_turnoff_low;
            offset_sign <= next_offset_sign;
            offset_low <= next_offset_low;
            react_select <= next_react_select;
            react_policy <= next_react_policy;
            loop_slave <= next_loop_slave;
            strap_taken <= next_strap_taken;
            resp <= next_resp;
            status <= next_status;
            smbalert_n <= next_smbalert_n;
        end
    end

    // Overvoltage reaction: ignore, latch off, or restart after the retry delay.
    always_comb begin
        next_state = state;
        next_wait_count = wait_count;
        next_soft_start = 1'b0;
        unique case (state)
            pmbus_cfg_pkg::ST_RUN: begin
                if (overvoltage_fault && react_select) begin // RULE_16 RULE_17
                    next_wait_count = '0;
                    next_state = react_policy ? pmbus_cfg_pkg::ST_RETRY_WAIT : pmbus_cfg_pkg::ST_LATCHED_OFF; // RULE_17
                end
            end
            pmbus_cfg_pkg::ST_LATCHED_OFF: begin
                if (clear_faults) begin
                    next_state = pmbus_cfg_pkg::ST_RUN; // RULE_17
                    next_soft_start = 1'b1;
                end
            end
            pmbus_cfg_pkg::ST_RETRY_WAIT: begin
                if (wait_count >= RETRY_WAIT_CYCLES - WAIT_W'(1)) begin
                    next_state = pmbus_cfg_pkg::ST_RUN; // RULE_19
                    next_soft_start = 1'b1;
                end else begin
                    next_wait_count = wait_count + WAIT_W'(1);
                end
            end
            default: begin
                next_state = pmbus_cfg_pkg::ST_RUN;
            end
        endcase
        next_regulate = (next_state == pmbus_cfg_pkg::ST_RUN);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= pmbus_cfg_pkg::ST_RUN;
            wait_count <= '0;
            regulate <= 1'b1;
            soft_start <= 1'b0;
        end else begin
            state <= next_state;
            wait_count <= next_wait_count;
            regulate <= next_regulate;
            soft_start <= next_soft_start;
        end
    end

    // Current correction by the signed offset.
    always_comb begin
        logic signed [15:0] offset_amps;
        offset_amps = $signed({{5{offset_sign}}, offset_sign, {4{offset_sign}}, offset_low});
        next_current_reported = current_raw + offset_amps; // RULE_09
        next_oc_fault_threshold = oc_fault_limit - offset_amps; // RULE_09
        next_oc_warn_threshold = oc_warn_limit - offset_amps; // RULE_09
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            current_reported <= '0;
            oc_fault_threshold <= '0;
            oc_warn_threshold <= '0;
        end else begin
            current_reported <= next_current_reported;
            oc_fault_threshold <= next_oc_fault_threshold;
            oc_warn_threshold <= next_oc_warn_threshold;
        end
    end

    // Store-all sequencer writes one image word per cycle.
    always_comb begin
        next_store_slot = store_slot;
        nv_write_en = 1'b0;
        nv_write_data = '0;
        unique case (store_slot)
            pmbus_cfg_pkg::SLOT_TURNOFF: nv_write_data = turnoff_word(turnoff_low); // RULE_08
            pmbus_cfg_pkg::SLOT_OFFSET: nv_write_data = offset_word(offset_sign, offset_low); // RULE_08
            pmbus_cfg_pkg::SLOT_REACTION: nv_write_data = reaction_word(react_select, react_policy); // RULE_08
            pmbus_cfg_pkg::SLOT_IDLE: nv_write_data = '0;
        endcase
        if (store_slot != pmbus_cfg_pkg::SLOT_IDLE) begin
            nv_write_en = 1'b1;
            next_store_slot = store_slot + 2'h1;
        end else if (store_all) begin
            next_store_slot = pmbus_cfg_pkg::SLOT_TURNOFF;
        end
        next_store_busy = (next_store_slot != pmbus_cfg_pkg::SLOT_IDLE);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            store_slot <= pmbus_cfg_pkg::SLOT_IDLE;
            store_busy <= 1'b0;
        end else begin
            store_slot <= next_store_slot;
            store_busy <= next_store_busy;
        end
    end

    nv_image_store #(
        .WIDTH(16),
        .DEPTH(3),
        .ADDR_W(2)
    ) image_store (
        .clock(clock),
        .write_en(nv_write_en),
        .write_addr(store_slot),
        .write_data(nv_write_data),
        .read_addr(cmd.code[1:0]),
        .read_data(nv_read_data)
    );

endmodule

`default_nettype wire

// ==== verif/pmbus_cfg_checker_assertions.sv ====
// Concurrent checks on the ports of the configuration command block.
`default_nettype none
module pmbus_cfg_checker (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Command port.
    input wire pmbus_cfg_pkg::cmd_t cmd,
    input wire pmbus_cfg_pkg::resp_t resp,
    input wire logic store_all,
    input wire logic loop_slave_strap,
    // Fault and current inputs.
    input wire logic overvoltage_fault,
    input wire logic overvoltage_alert_mask,
    input wire logic signed [15:0] current_raw,
    input wire logic signed [15:0] oc_fault_limit,
    // Observed outputs.
    input wire logic signed [15:0] current_reported,
    input wire logic signed [15:0] oc_fault_threshold,
    input wire pmbus_cfg_pkg::status_t status,
    input wire logic smbalert_n,
    input wire logic regulate,
    input wire logic soft_start,
    input wire logic store_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic after_reset, slave;
    // Strap taken at the first edge after reset, as in the block.
    always_ff @(posedge clock) begin
        after_reset <= reset;
        if (after_reset && !reset) begin
            slave <= loop_slave_strap;
        end
    end
    sequence s_store_run;
        store_busy ##1 store_busy ##[1:3] !store_busy;
    endsequence
    a_turnoff_fixed: assert property (cmd.valid && !cmd.write && cmd.code == 8'h36 |=>
        resp.data[15:7] == 9'h1E0) else $error("turnoff fixed bits wrong");
    a_offset_fixed: assert property (cmd.valid && !cmd.write && cmd.code == 8'h39 |=>
        resp.data[15:11] == 5'h1C && resp.data[9:6] == {4{resp.data[10]}}) else $error("offset fixed bits wrong");
    a_delay_mirror: assert property (cmd.valid && !cmd.write && cmd.code == 8'h41 && !slave |=>
        !resp.data[6] && resp.data[4:0] == {5{resp.data[5]}}) else $error("retry delay not mirrored");
    a_ov_flags: assert property (overvoltage_fault |=>
        status.status_byte[5] && status.status_word[15] && status.status_vout[7]) else $error("ov flags missing");
    a_ov_alert: assert property (overvoltage_fault && !overvoltage_alert_mask |=> !smbalert_n)
        else $error("ov alert missing");
    a_cml_alert: assert property (status.status_cml[7] || status.status_cml[6] |->
        !smbalert_n && status.status_byte[1]) else $error("cml fault without alert");
    a_slave_nack: assert property (cmd.valid && cmd.code == 8'h41 && slave && !after_reset |=>
        resp.nack && status.status_cml[7]) else $error("slave access not refused");
    a_offset_applied: assert property (!$past(reset) && !$past(reset, 2) |->
        16'(current_reported + oc_fault_threshold) == 16'($past(current_raw) + $past(oc_fault_limit)))
        else $error("offset not applied evenly");
    a_store_steps: assert property (store_all && !store_busy |=> s_store_run)
        else $error("store sequence wrong");
    a_shutdown_cause: assert property ($fell(regulate) |-> $past(overvoltage_fault))
        else $error("shutdown without fault");
    a_restart_soft: assert property (soft_start |-> regulate)
        else $error("soft start while off");
endmodule
bind pmbus_input_turnoff_threshold_iout_ov_cfg pmbus_cfg_checker pmbus_cfg_checker_inst (.clock, .reset,
    .cmd, .resp, .store_all, .loop_slave_strap, .overvoltage_fault, .overvoltage_alert_mask,
    .current_raw, .oc_fault_limit, .current_reported, .oc_fault_threshold, .status, .smbalert_n,
    .regulate, .soft_start, .store_busy);
`default_nettype wire

// ==== verif/pmbus_host_model.sv ====
// Host side model that issues decoded PMBus commands and collects the answers.
`default_nettype none
module pmbus_host_model (
    // Clock.
    input wire logic clock,
    // Command out, answer in.
    output var pmbus_cfg_pkg::cmd_t cmd,
    input wire pmbus_cfg_pkg::resp_t resp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd = 26'hFFFFFF;
    // Raised after an edge, taken at the next; the answer is read just after.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output pmbus_cfg_pkg::resp_t r);
        @(posedge clock);
        #1 cmd = {1'b1, wr, code, data};
        @(posedge clock);
        #1 r = resp;
        cmd = {2'b00, ~code, ~data};
    endtask
endmodule
`default_nettype wire

// ==== verif/pmbus_input_turnoff_threshold_iout_ov_cfg_tb.sv ====
// Self-checking bench for the configuration command block.
`default_nettype none
module pmbus_input_turnoff_threshold_iout_ov_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] code;
        logic [4:0] turnon;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic bad;
    } row_t;
    row_t rows [16] = '{
        '{8'h36, 5'h1F, 16'hF014, 16'hF014, 1'b0}, '{8'h36, 5'h1F, 16'hF01E, 16'hF01E, 1'b0},
        '{8'h36, 5'h1F, 16'hF01F, 16'hF01E, 1'b1}, '{8'h36, 5'h1F, 16'hF00F, 16'hF01E, 1'b1},
        '{8'h36, 5'h1F, 16'hE829, 16'hF015, 1'b0}, '{8'h36, 5'h14, 16'hF014, 16'hF015, 1'b1},
        '{8'h36, 5'h14, 16'hF013, 16'hF013, 1'b0}, '{8'h39, 5'h1F, 16'h0005, 16'hE005, 1'b0},
        '{8'h39, 5'h1F, 16'h0400, 16'hE7C0, 1'b0}, '{8'h39, 5'h1F, 16'h0040, 16'hE000, 1'b0},
        '{8'h39, 5'h1F, 16'hFFFF, 16'hE7FF, 1'b0}, '{8'h41, 5'h1F, 16'h0000, 16'h0000, 1'b0},
        '{8'h41, 5'h1F, 16'h00B8, 16'h00BF, 1'b0}, '{8'h41, 5'h1F, 16'h0090, 16'h00BF, 1'b1},
        '{8'h41, 5'h1F, 16'h0040, 16'h0000, 1'b0}, '{8'h41, 5'h1F, 16'h0080, 16'h0080, 1'b0}};
    logic [15:0] stored [3] = '{16'hF013, 16'hE7FF, 16'h0080};
    logic clock = 1'b0, reset = 1'b1, store_all = 1'b0, clear_faults = 1'b0, strap = 1'b0, ov = 1'b0, ov_mask = 1'b0;
    logic [4:0] turnon = 5'h1F;
    logic signed [15:0] cur = 16'sh0064, flim = 16'sh00C8, wlim = 16'sh0096;
    logic signed [15:0] cur_rep, fthr, wthr;
    logic [15:0] nv_data;
    logic alert_n, regulate, soft_start, store_busy;
    pmbus_cfg_pkg::cmd_t cmd;
    pmbus_cfg_pkg::resp_t resp, r;
    pmbus_cfg_pkg::status_t st;
    int mismatches = 0, num_checks = 0, n;
    pmbus_input_turnoff_threshold_iout_ov_cfg #(.RISE_CYCLES(4)) pmbus_input_turnoff_threshold_iout_ov_cfg_inst (
        .clock, .reset, .cmd, .resp, .store_all,
        .clear_faults, .loop_slave_strap(strap), .turnon_mantissa(turnon),
        .overvoltage_fault(ov), .overvoltage_alert_mask(ov_mask), .current_raw(cur),
        .oc_fault_limit(flim), .oc_warn_limit(wlim), .current_reported(cur_rep),
        .oc_fault_threshold(fthr), .oc_warn_threshold(wthr), .status(st), .smbalert_n(alert_n),
        .regulate, .soft_start, .store_busy, .nv_read_data(nv_data));
    pmbus_host_model pmbus_host_model_inst (.clock, .cmd, .resp);
    task automatic xf(input logic wr, input logic [7:0] code, input logic [15:0] data);
        pmbus_host_model_inst.xfer(wr, code, data, r);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(input logic fault);
        @(posedge clock);
        #1 {ov, clear_faults} = {fault, !fault};
        @(posedge clock);
        #1 {ov, clear_faults} = 2'b00;
    endtask
    task automatic wait_soft(input int lim);
        n = 0;
        while (soft_start !== 1'b1 && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
    endtask
    task automatic do_reset(input logic s);
        @(posedge clock);
        #1 reset = 1'b1;
        strap = s;
        repeat (2) @(posedge clock);
        #1 reset = 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
    initial begin
        do_reset(1'b0);
        xf(1'b0, 8'h36, 16'h0000);
        check("turnoff reset", 16'hF010, r.data);
        xf(1'b0, 8'h39, 16'h0000);
        check("offset reset", 16'hE000, r.data);
        xf(1'b0, 8'h41, 16'h0000);
        check("reaction reset", 16'h00BF, r.data);
        pulse(1'b1);
        check("ov flags", 16'h0007, 16'({st.status_byte[5], st.status_word[15], st.status_vout[7]}));
        check("ov shutdown", 16'h0000, 16'({regulate, alert_n}));
        wait_soft(60);
        check("retry restart", 16'h0007, 16'({n >= 26 && n <= 30, regulate, soft_start}));
        foreach (rows[i]) begin
            pulse(1'b0);
            turnon = rows[i].turnon;
            xf(1'b1, rows[i].code, rows[i].wdata);
            check("write nack", 16'h0000, 16'(r.nack));
            check("reject flags", rows[i].bad ? 16'h0007 : 16'h0000,
                16'({st.status_cml[6], st.status_byte[1], !alert_n}));
            xf(1'b0, rows[i].code, 16'h0000);
            check("read back", rows[i].rdata, r.data);
        end
        check("current", 16'h0063, cur_rep);
        check("fault limit", 16'h00C9, fthr);
        check("warn limit", 16'h0097, wthr);
        @(posedge clock);
        #1 store_all = 1'b1;
        @(posedge clock);
        #1 store_all = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        check("store busy", 16'h0000, 16'(store_busy));
        foreach (stored[i]) begin
            xf(1'b0, 8'(i), 16'h0000);
            check("image word", stored[i], nv_data);
            check("unknown nack", 16'h0001, 16'(r.nack));
        end
        pulse(1'b0);
        pulse(1'b1);
        wait_soft(40);
        check("latched off", 16'h0000, 16'({soft_start, regulate}));
        pulse(1'b0);
        wait_soft(3);
        check("release", 16'h0003, 16'({regulate, soft_start}));
        xf(1'b1, 8'h41, 16'h0000);
        ov_mask = 1'b1;
        pulse(1'b1);
        check("ignore masked", 16'h0007, 16'({regulate, alert_n, st.status_vout[7]}));
        ov_mask = 1'b0;
        pulse(1'b1);
        check("ignore alert", 16'h0002, 16'({regulate, alert_n}));
        do_reset(1'b1);
        xf(1'b1, 8'h41, 16'h0000);
        check("slave refusal", 16'h000F, 16'({r.nack, st.status_cml[7], st.status_byte[1], !alert_n}));
        pulse(1'b1);
        check("slave write ignored", 16'h0000, 16'(regulate));
        close_out();
    end
endmodule
`default_nettype wire
